// ==== counter_pkg.sv ====
// Constants, types and helpers for the period / pulse-width / one-shot counter channel
package counter_pkg;

	// Control word layout
	localparam int CTRL_W       = 16;
	localparam int MODE_LSB     = 0;
	localparam int OUT_POL_BIT  = 3;
	localparam int MEAS_POL_LSB = 4;
	localparam int TRIG_POL_LSB = 8;
	localparam int CLK_SEL_LSB  = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_USED  = 16'h1f3f;

	// Mode codes in control bits 2:0
	localparam logic [2:0] MODE_PULSE   = 3'h5;
	localparam logic [2:0] MODE_PERIOD  = 3'h6;
	localparam logic [2:0] MODE_ONESHOT = 3'h7;

	// Two-bit polarity codes for the measure and trigger inputs
	localparam logic [1:0] POL_LOW  = 2'h1;
	localparam logic [1:0] POL_HIGH = 2'h2;

	// Count clock selection codes
	localparam logic [2:0] CLK_SEL_0 = 3'h0;
	localparam logic [2:0] CLK_SEL_1 = 3'h1;
	localparam logic [2:0] CLK_SEL_2 = 3'h2;
	localparam logic [2:0] CLK_SEL_3 = 3'h3;
	localparam logic [2:0] CLK_SEL_4 = 3'h4;

	// Phase increments: rate / 40 MHz scaled by 2^16; the fastest rate caps at one per clock
	localparam int ACC_W = 16;
	localparam logic [ACC_W:0] CLK_INC_0 = 17'h00c80;
	localparam logic [ACC_W:0] CLK_INC_1 = 17'h01900;
	localparam logic [ACC_W:0] CLK_INC_2 = 17'h03200;
	localparam logic [ACC_W:0] CLK_INC_3 = 17'h06400;
	localparam logic [ACC_W:0] CLK_INC_4 = 17'h10000;
	localparam logic [ACC_W:0] CLK_INC_0FF = 17'h00000;

	// Counter limits
	localparam logic [31:0] CNT_OVF  = 32'h0fffffff;
	localparam logic [31:0] CNT_ZERO = 32'h00000000;

	// Interrupt information bits
	localparam int INFO_W       = 6;
	localparam int INFO_OUT_BIT = 3;
	localparam int INFO_END_BIT = 4;

	// Register write selectors
	localparam logic [2:0] SEL_CTRL    = 3'h0;
	localparam logic [2:0] SEL_CONST_A = 3'h1;
	localparam logic [2:0] SEL_CONST_B = 3'h2;
	localparam logic [2:0] SEL_TRIGGER = 3'h3;
	localparam logic [2:0] SEL_INT_EN  = 3'h4;
	localparam logic [2:0] SEL_INT_CLR = 3'h5;

	// Completion pulse: printed time, then a least count of 25 ns clocks
	localparam int CLK_PERIOD_NS = 25;
	localparam int DONE_PULSE_NS = 1728;
	localparam int DONE_PULSE_CYC = (DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] DONE_PULSE_LOAD = 8'(DONE_PULSE_CYC);
	localparam logic [7:0] DONE_PULSE_IDLE = 8'h00;

	// Channel sequencing states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ARM   = 3'h1,
		ST_MEAS  = 3'h3,
		ST_DELAY = 3'h4,
		ST_WIDTH = 3'h5
	} state_type;

	// One register write from software
	typedef struct packed {
		logic        valid;
		logic [2:0]  sel;
		logic [31:0] data;
	} reg_write_type;

	// Register read-back view
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [31:0]       readback;
		logic [INFO_W-1:0] info;
		logic              int_en;
	} reg_read_type;

	// True when the level is the active one for an enabled polarity code
	function automatic logic level_active(input logic [1:0] pol, input logic lvl);
		level_active = (pol == POL_LOW) ? ~lvl : ((pol == POL_HIGH) ? lvl : 1'b0);
	endfunction

	// True when the polarity code enables the input
	function automatic logic pol_enabled(input logic [1:0] pol);
		pol_enabled = (pol == POL_LOW) || (pol == POL_HIGH);
	endfunction

	// Phase increment for a count clock selection
	function automatic logic [ACC_W:0] clk_inc(input logic [2:0] sel);
		case (sel)
			CLK_SEL_0: clk_inc = CLK_INC_0;
			CLK_SEL_1: clk_inc = CLK_INC_1;
			CLK_SEL_2: clk_inc = CLK_INC_2;
			CLK_SEL_3: clk_inc = CLK_INC_3;
			CLK_SEL_4: clk_inc = CLK_INC_4;
			default:   clk_inc = CLK_INC_0FF;
		endcase
	endfunction

endpackage

// ==== count_tick_gen.sv ====
// Count clock tick generator: phase accumulator giving the selected count rate
`timescale 1ns/1ps
module count_tick_gen (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] clk_sel_i,
	output logic            tick_o
);
	import counter_pkg::*;

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W:0]   sum;

	// Carry out of the accumulator marks one count clock
	assign sum = {1'b0, acc_q} + clk_inc(clk_sel_i);

	// Accumulator and registered tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_q  <= '0;
			tick_o <= 1'b0;
		end else begin
			acc_q  <= sum[ACC_W-1:0];
			tick_o <= sum[ACC_W];
		end
	end

endmodule

// ==== counter_channel.sv ====
// Counter channel: pulse-width and period measurement, one-shot generation
`timescale 1ns/1ps
module counter_channel (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire counter_pkg::reg_write_type wr_i,
	input  wire logic                       measure_gate_input_i,
	input  wire logic                       trigger_input_i,
	output counter_pkg::reg_read_type       rd_o,
	output logic                            counter_out_o,
	output logic                            irq_o
);
	import counter_pkg::*;

	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic [31:0]       const_a_q;
	logic [31:0]       const_b_q;
	logic              int_en_q;
	logic              int_en_d;
	logic [INFO_W-1:0] info_q;
	logic [INFO_W-1:0] info_d;
	logic [31:0]       cnt_q;
	logic [31:0]       cnt_d;
	state_type         state_q;
	state_type         state_d;
	logic              act_q;
	logic [7:0]        pulse_q;
	logic              meas_prev_q;
	logic              trig_prev_q;
	logic              tick;
	logic [2:0]        mode;
	logic [1:0]        meas_pol;
	logic [1:0]        trig_pol;
	logic              meas_act;
	logic              meas_rise;
	logic              meas_fall;
	logic              sw_trig;
	logic              trig_evt;
	logic              is_measure;
	logic              is_oneshot;
	logic              gate_run;
	logic              meas_done;
	logic              os_zero;
	logic              out_act;

	// Control field decode
	assign mode     = ctrl_q[MODE_LSB +: 3];
	assign meas_pol = ctrl_q[MEAS_POL_LSB +: 2];
	assign trig_pol = ctrl_q[TRIG_POL_LSB +: 2];
	assign is_measure = (mode == MODE_PULSE) || (mode == MODE_PERIOD);
	assign is_oneshot = (mode == MODE_ONESHOT);

	// Count clock ticks at the selected rate
	count_tick_gen u_tick (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.clk_sel_i (ctrl_q[CLK_SEL_LSB +: 3]),
		.tick_o    (tick)
	);

	// Edge and level detection on the field inputs
	assign meas_act  = level_active(meas_pol, measure_gate_input_i);
	assign meas_rise = meas_act & ~level_active(meas_pol, meas_prev_q);
	assign meas_fall = ~meas_act & level_active(meas_pol, meas_prev_q);
	assign sw_trig   = wr_i.valid && (wr_i.sel == SEL_TRIGGER);
	assign trig_evt  = sw_trig | (level_active(trig_pol, trigger_input_i) &
		~level_active(trig_pol, trig_prev_q));

	// Gate runs the one-shot when the measure input is at its enabling level
	assign gate_run  = pol_enabled(meas_pol) ? meas_act : 1'b1;
	assign meas_done = (state_q == ST_MEAS) &&
		((mode == MODE_PULSE) ? meas_fall : meas_rise);
	assign os_zero   = ((state_q == ST_DELAY) || (state_q == ST_WIDTH)) &&
		(cnt_q == CNT_ZERO) && gate_run;
	assign out_act   = act_q | (pulse_q != DONE_PULSE_IDLE);

	// Previous input levels for edge detection
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meas_prev_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			meas_prev_q <= measure_gate_input_i;
			trig_prev_q <= trigger_input_i;
		end
	end

	// Software-written registers
	always_comb begin
		ctrl_d   = ctrl_q;
		int_en_d = int_en_q;
		if (wr_i.valid && (wr_i.sel == SEL_CTRL)) begin
			ctrl_d = wr_i.data[CTRL_W-1:0] & CTRL_USED;
		end
		if (wr_i.valid && (wr_i.sel == SEL_INT_EN)) begin
			int_en_d = wr_i.data[0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q    <= CTRL_RESET;
			int_en_q  <= 1'b0;
			const_a_q <= CNT_ZERO;
			const_b_q <= CNT_ZERO;
		end else begin
			ctrl_q   <= ctrl_d;
			int_en_q <= int_en_d;
			if (wr_i.valid && (wr_i.sel == SEL_CONST_A)) begin
				const_a_q <= wr_i.data;
			end
			if (wr_i.valid && (wr_i.sel == SEL_CONST_B)) begin
				const_b_q <= wr_i.data;
			end
		end
	end

	// Sequencing: arm, measure, or run the two one-shot phases
	always_comb begin
		state_d = state_q;
		if (!is_measure && !is_oneshot) begin
			state_d = ST_IDLE;
		end else if (trig_evt) begin
			state_d = is_oneshot ? ST_DELAY : ST_ARM;
		end else begin
			unique case (state_q)
				ST_IDLE: state_d = ST_IDLE;
				ST_ARM: begin
					if (meas_rise) state_d = ST_MEAS;
				end
				ST_MEAS: begin
					if (meas_done) state_d = ST_IDLE;
				end
				ST_DELAY: begin
					if (os_zero) state_d = ST_WIDTH;
				end
				ST_WIDTH: begin
					if (os_zero) state_d = ST_IDLE;
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Counter: up-count while measuring, down-count through one-shot phases
	always_comb begin
		cnt_d = cnt_q;
		if (trig_evt && is_measure) begin
			cnt_d = CNT_ZERO;
		end else if (trig_evt && is_oneshot) begin
			cnt_d = const_a_q;
		end else if ((state_q == ST_MEAS) && !meas_done && tick) begin
			if (cnt_q != CNT_OVF) cnt_d = cnt_q + 32'h1;
		end else if (state_q == ST_DELAY && os_zero) begin
			cnt_d = const_b_q;
		end else if ((state_q == ST_DELAY || state_q == ST_WIDTH) && tick && gate_run) begin
			if (cnt_q != CNT_ZERO) cnt_d = cnt_q - 32'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// One-shot output level: active after A runs out, inactive after B
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			act_q <= 1'b0;
		end else if (trig_evt || state_d == ST_IDLE) begin
			act_q <= 1'b0;
		end else if (os_zero) begin
			act_q <= (state_q == ST_DELAY);
		end
	end

	// Completion pulse timer for the measurement modes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_q <= DONE_PULSE_IDLE;
		end else if (meas_done) begin
			pulse_q <= DONE_PULSE_LOAD;
		end else if (pulse_q != DONE_PULSE_IDLE) begin
			pulse_q <= pulse_q - 8'h01;
		end
	end

	// Interrupt information: hardware set wins over a write-one clear
	always_comb begin
		info_d = info_q;
		if (wr_i.valid && (wr_i.sel == SEL_INT_CLR)) begin
			info_d = info_q & ~wr_i.data[INFO_W-1:0];
		end
		if (int_en_q && meas_done) begin
			info_d[INFO_END_BIT] = 1'b1;
		end
		if (int_en_q && os_zero) begin
			info_d[INFO_OUT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			info_q <= '0;
			irq_o  <= 1'b0;
		end else begin
			info_q <= info_d;
			irq_o  <= |info_d;
		end
	end

	// Registered pin and read-back outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			counter_out_o <= 1'b1;
			rd_o          <= '0;
		end else begin
			counter_out_o <= ctrl_q[OUT_POL_BIT] ? out_act : ~out_act;
			rd_o.ctrl     <= ctrl_d;
			rd_o.readback <= cnt_d;
			rd_o.info     <= info_d;
			rd_o.int_en   <= int_en_d;
		end
	end

	// Checks
	trig_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(trig_evt && is_measure) |=> (cnt_q == CNT_ZERO) && (state_q == ST_ARM))
		else $error("Trigger did not clear and arm the counter");
	period_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_ARM && meas_rise && !trig_evt && is_measure) |=> state_q == ST_MEAS)
		else $error("Active edge did not start the measurement");
	done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		meas_done |=> (pulse_q == DONE_PULSE_LOAD) ##1
		(counter_out_o == $past(ctrl_q[OUT_POL_BIT])))
		else $error("Completion pulse not driven on the pin");
	count_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_MEAS && cnt_q == CNT_OVF && !trig_evt) |=> cnt_q == CNT_OVF)
		else $error("Counter left the overflow value");
	end_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(meas_done && int_en_q) |=> info_q[INFO_END_BIT] && irq_o)
		else $error("End of measurement not flagged");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(info_q[INFO_END_BIT] && !(wr_i.valid && wr_i.sel == SEL_INT_CLR))
		|=> info_q[INFO_END_BIT])
		else $error("Pending flag dropped without a clear");
	oneshot_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(trig_evt && is_oneshot) |=> (state_q == ST_DELAY) && (cnt_q == $past(const_a_q)))
		else $error("One-shot trigger did not load constant A");
	zero_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(os_zero && state_q == ST_DELAY && !trig_evt && is_oneshot)
		|=> act_q && (cnt_q == $past(const_b_q)) && (state_q == ST_WIDTH))
		else $error("Zero count did not toggle and load constant B");
	gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_WIDTH && !gate_run && !trig_evt && is_oneshot) |=> $stable(cnt_q))
		else $error("Counter moved while gated off");
	edge_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(os_zero && int_en_q) |=> info_q[INFO_OUT_BIT])
		else $error("Output transition not flagged");
	width_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(os_zero && state_q == ST_WIDTH && !trig_evt && is_oneshot)
		|=> !act_q && (state_q == ST_IDLE))
		else $error("Width phase did not end the one-shot");
	pin_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 counter_out_o == ($past(ctrl_q[OUT_POL_BIT]) ~^ $past(out_act)))
		else $error("Output pin level does not follow its polarity");

endmodule

// ==== field_side_model.sv ====
// Field-side model: drives the measure/gate and trigger pins of one channel
`timescale 1ns/1ps
module field_side_model (
	input  wire logic clk_i,
	output logic      measure_o,
	output logic      trigger_o
);
	int   lo_cyc;
	int   hi_cyc;
	int   run_cnt;
	logic run_q;

	// Pins start low with the square wave stopped
	initial begin
		measure_o = 1'b0;
		trigger_o = 1'b0;
		run_q = 1'b0;
		run_cnt = 0;
	end

	// Square wave with separately timed low and high phases while running
	always @(posedge clk_i) begin
		if (run_q) begin
			run_cnt++;
			if (run_cnt >= (measure_o ? hi_cyc : lo_cyc)) begin
				run_cnt = 0;
				measure_o <= #1 ~measure_o;
			end
		end
	end

	// Start or stop the wave; changes land just after an edge
	task automatic wave(input int lo, input int hi, input logic on);
		@(posedge clk_i);
		#1;
		lo_cyc = lo;
		hi_cyc = hi;
		run_cnt = 0;
		run_q = on;
	endtask

	// Stop the wave and hold a fixed gate level
	task automatic level(input logic v);
		@(posedge clk_i);
		#1;
		run_q = 1'b0;
		measure_o = v;
	endtask

	// Park the trigger pin at its inactive level
	task automatic idle(input logic v);
		@(posedge clk_i);
		#1;
		trigger_o = v;
	endtask

	// Hold the trigger at its active level for three clocks, then release
	task automatic fire();
		@(posedge clk_i);
		#1;
		trigger_o = ~trigger_o;
		repeat (3) @(posedge clk_i);
		#1;
		trigger_o = ~trigger_o;
	endtask
endmodule

// ==== testbench.sv ====
// Self-checking testbench for the counter channel with a field-side model
`timescale 1ns/1ps
module testbench;
	import counter_pkg::*;
	typedef struct {bit kind; int val; int tol;} note_type;
	logic          clk_i;
	logic          rst_i;
	reg_write_type wr_i;
	reg_read_type  rd_o;
	logic          counter_out_o;
	logic          irq_o;
	logic          measure_w;
	logic          trigger_w;
	note_type      notes[$];
	int            fails = 0;
	int            samples_checked = 0;
	int            run_len = 0;
	logic          watch = 1'b0;
	logic          out_pol = 1'b0;
	logic          info4_q = 1'b0;
	logic [31:0]   rng = 32'h470f;
	int            s, p, lo, hi, a, b, g, n, k;
	logic [1:0]    pol;

	counter_channel i_counter_channel (
		.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .measure_gate_input_i(measure_w),
		.trigger_input_i(trigger_w), .rd_o(rd_o), .counter_out_o(counter_out_o), .irq_o(irq_o)
	);
	field_side_model i_field_side_model (.clk_i(clk_i), .measure_o(measure_w), .trigger_o(trigger_w));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Xorshift source for random constants and wave timing
	function automatic int rnd(input int span);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return int'(rng % span);
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic near(input logic [31:0] got, input note_type nt);
		samples_checked++;
		if (^got === 1'bx || int'(got) + nt.tol < nt.val || int'(got) > nt.val + nt.tol) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, nt.val);
		end
	endtask

	task automatic expect_res(input bit kind, input int val, input int tol);
		notes.push_back('{kind, val, tol});
	endtask

	// Compare a finished result with the oldest note of the driver
	task automatic take(input bit kind, input logic [31:0] got);
		if (notes.size() == 0 || notes[0].kind != kind) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, 32'h0);
		end else begin
			near(got, notes.pop_front());
		end
	endtask

	// One register write, strobe held for exactly one edge
	task automatic wr(input logic [2:0] sel, input logic [31:0] data);
		@(posedge clk_i);
		#1;
		wr_i = '{1'b1, sel, data};
		@(posedge clk_i);
		#1;
		wr_i.valid = 1'b0;
	endtask

	// Wait for all notes to be matched, bounded
	task automatic drain();
		for (int w = 0; w < 20000 && notes.size() > 0; w++) begin
			@(posedge clk_i);
			#1;
		end
		if (notes.size() > 0) begin
			fails++;
			wrap_up();
		end
	endtask

	// Program the control word with the active-run length monitor paused across the change
	task automatic setup(input logic [2:0] md, input logic [1:0] mp, input logic [1:0] tp,
		input logic [2:0] cs, input logic op);
		watch = 1'b0;
		// New polarity first, then park the pin, so no false trigger edge appears
		wr(SEL_CTRL, {19'h0, cs, tp, 2'b00, mp, op, md});
		i_field_side_model.idle(tp == POL_LOW);
		out_pol = op;
		repeat (3) @(posedge clk_i);
		#1;
		watch = 1'b1;
	endtask

	// Monitor: readback at end of measurement, output active-run length
	always @(negedge clk_i) begin
		if (rd_o.info[4] === 1'b1 && !info4_q) take(1'b0, rd_o.readback);
		info4_q = (rd_o.info[4] === 1'b1);
		if (!watch) begin
			run_len = 0;
		end else if (counter_out_o === out_pol) begin
			run_len++;
		end else if (run_len > 0) begin
			take(1'b1, run_len);
			run_len = 0;
		end
	end

	// Main sequence
	initial begin
		wr_i = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		check(rd_o.ctrl, 32'h0);
		check(counter_out_o, 1'b1);
		check(irq_o, 1'b0);
		wr(SEL_CTRL, 32'hffff);
		check(rd_o.ctrl, 32'h1f3f);
		wr(SEL_INT_EN, 32'h1);
		check(rd_o.int_en, 1'b1);
		$display("test registers done");
		for (s = 0; s < 5; s++) begin
			p = 300 + rnd(300);
			lo = p / 3;
			setup(MODE_PERIOD, s[0] ? POL_LOW : POL_HIGH, 2'h0, s[2:0], 1'b0);
			i_field_side_model.wave(lo, p - lo, 1'b1);
			expect_res(1'b0, (s == 4) ? p : p * 25 * (1 << s) / 512, 2);
			expect_res(1'b1, DONE_PULSE_CYC, 0);
			wr(SEL_TRIGGER, 32'h0);
			drain();
			check(rd_o.info, 6'h10);
			check(irq_o, 1'b1);
			wr(SEL_INT_CLR, 32'h10);
			check(irq_o, 1'b0);
		end
		$display("test period done");
		for (k = 0; k < 2; k++) begin
			pol = k ? POL_HIGH : POL_LOW;
			lo = 20 + rnd(60);
			hi = 20 + rnd(60);
			setup(MODE_PULSE, pol, pol, 3'h4, 1'b1);
			i_field_side_model.wave(lo, hi, 1'b1);
			expect_res(1'b0, k ? hi : lo, 2);
			expect_res(1'b1, DONE_PULSE_CYC, 0);
			i_field_side_model.fire();
			drain();
			wr(SEL_INT_CLR, 32'h3f);
		end
		setup(MODE_PERIOD, POL_HIGH, 2'h3, 3'h4, 1'b0);
		i_field_side_model.fire();
		repeat (400) @(posedge clk_i);
		#1;
		check(rd_o.info, 6'h00);
		$display("test pulse width and trigger done");
		i_field_side_model.level(1'b1);
		setup(MODE_ONESHOT, 2'h0, 2'h0, 3'h4, 1'b1);
		for (k = 0; k < 2; k++) begin
			a = 4 + rnd(40);
			b = 4 + rnd(40);
			wr(SEL_CONST_A, a);
			wr(SEL_CONST_B, b);
			expect_res(1'b1, b + 1, 0);
			wr(SEL_TRIGGER, 32'h0);
			for (n = 0; n < 200 && counter_out_o !== 1'b1; n++) begin
				@(posedge clk_i);
				#1;
			end
			near(n, '{1'b1, a + 2, 1});
			check(irq_o, 1'b1);
			wr(SEL_INT_CLR, 32'h08);
			check(irq_o, 1'b0);
			drain();
			check(rd_o.info, 6'h08);
			wr(SEL_INT_CLR, 32'h08);
		end
		setup(MODE_ONESHOT, POL_HIGH, 2'h0, 3'h4, 1'b1);
		g = 5 + rnd(20);
		expect_res(1'b1, b + 1 + g, 1);
		wr(SEL_TRIGGER, 32'h0);
		for (n = 0; n < 200 && counter_out_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		near(n, '{1'b1, a + 2, 1});
		i_field_side_model.level(1'b0);
		repeat (g - 1) @(posedge clk_i);
		i_field_side_model.level(1'b1);
		drain();
		$display("test one-shot done");
		wrap_up();
	end
endmodule
